// ==== status_output_selector_consts.svh ====
/*
 * constants for the status output selector: assignment codes, terminal
 * count, field widths and reset values.
 * assumes it is included by bare name wherever the codes are decoded.
 */
`ifndef STATUS_OUTPUT_SELECTOR_CONSTS_SVH
`define STATUS_OUTPUT_SELECTOR_CONSTS_SVH

`define SOS_NUM_TERMINALS     8
`define SOS_TERM_IDX_W        3
`define SOS_CODE_W            8
`define SOS_NUM_INPUT_FUNCS   128
`define SOS_STATUS_W          27
`define SOS_ECHO_IDX_MSB      6

`define SOS_CODE_RESET        8'h00
`define SOS_CODE_UNUSED       8'h00
`define SOS_CODE_ECHO_LAST    8'h7f
`define SOS_CODE_CONST_OFF    8'h80
`define SOS_CODE_ALARM_HIGH   8'h81
`define SOS_CODE_ALARM_LOW    8'h82
`define SOS_CODE_SYS_PREP     8'h83
`define SOS_CODE_READY        8'h84
`define SOS_CODE_MOVING       8'h86
`define SOS_CODE_INFORMATION_FLAG         8'h87
`define SOS_CODE_BUSY         8'h88
`define SOS_CODE_IN_POSITION  8'h8a
`define SOS_CODE_TORQUE_LIM   8'h8c
`define SOS_CODE_SPEED_REACH  8'h8d
`define SOS_CODE_EXCITED      8'h8e
`define SOS_CODE_CUTBACK      8'h8f
`define SOS_CODE_HOME_END     8'h90
`define SOS_CODE_COORD_SET    8'h91
`define SOS_CODE_PRESET_REQ   8'h95
`define SOS_CODE_MECH_HOME    8'h96
`define SOS_CODE_FACT_HOME    8'h97
`define SOS_CODE_WRAP_TOGGLE  8'h98
`define SOS_CODE_FWD_LIMIT    8'h99
`define SOS_CODE_REV_LIMIT    8'h9a
`define SOS_CODE_STATUS_LAST  8'h9a

`define SOS_FLAG_RESET        1'b0

`endif

// ==== status_output_selector_pkg.sv ====
/*
 * types shared by the status output selector and its helpers.
 * assumes the constants header is on the include path.
 */
`include "status_output_selector_consts.svh"

package status_output_selector_pkg;
   typedef logic [`SOS_CODE_W-1:0]          assign_code_t;
   typedef logic [`SOS_TERM_IDX_W-1:0]      term_idx_t;
   typedef logic [`SOS_NUM_TERMINALS-1:0]   term_vec_t;
   typedef logic [`SOS_NUM_INPUT_FUNCS-1:0] input_vec_t;
   typedef logic [`SOS_STATUS_W-1:0]        status_vec_t;
endpackage : status_output_selector_pkg

// ==== event_toggle_flag.sv ====
/*
 * toggle flag: the level inverts once for every event pulse.
 * assumes the event is a one-cycle pulse on the same clock.
 */
`include "status_output_selector_consts.svh"

module event_toggle_flag
   import status_output_selector_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic event_in,
   output logic      level_out
);
   logic level_q;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         level_q <= `SOS_FLAG_RESET;
      end else if (event_in) begin
         level_q <= ~level_q;
      end
   end

   assign level_out = level_q;
endmodule : event_toggle_flag

// ==== sticky_event_flag.sv ====
/*
 * sticky flag: set by an event pulse, cleared by a clear pulse.
 * assumes both pulses come from logic on the same clock.
 */
`include "status_output_selector_consts.svh"

module sticky_event_flag
   import status_output_selector_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic set_in,
   input  wire logic clear_in,
   output logic      flag_out
);
   logic flag_q;

   // a set in the cycle of a clear is kept
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_q <= `SOS_FLAG_RESET;
      end else if (set_in) begin
         flag_q <= 1'b1;
      end else if (clear_in) begin
         flag_q <= 1'b0;
      end
   end

   assign flag_out = flag_q;
endmodule : sticky_event_flag

// ==== status_output_selector.sv ====
/*
 * output function selector: each output terminal holds an assignment
 * code, and the code picks the input echo or status flag that drives
 * the terminal.
 * assumes every flag and input function state comes from driver logic
 * on clk_in, so none of them is resynchronised here; event inputs are
 * one-cycle pulses.
 */
`include "status_output_selector_consts.svh"

module status_output_selector
   import status_output_selector_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         arst_n_in,
   // assignment code load and readback
   input  wire logic         code_wr_en_in,
   input  wire term_idx_t    code_wr_sel_in,
   input  wire assign_code_t code_wr_data_in,
   input  wire term_idx_t    code_rd_sel_in,
   output assign_code_t      code_rd_data_out,
   // input function states, bit n for function n
   input  wire input_vec_t   input_func_in,
   // driver status flags
   input  wire logic         alarm_present_in,
   input  wire logic         system_prepared_in,
   input  wire logic         drive_ready_in,
   input  wire logic         motor_moving_in,
   input  wire logic         information_flag_in,
   input  wire logic         internal_processing_flag_in,
   input  wire logic         positioning_done_in,
   input  wire logic         torque_at_limit_in,
   input  wire logic         speed_reached_in,
   input  wire logic         motor_excited_in,
   input  wire logic         current_cutback_active_in,
   input  wire logic         coordinate_established_in,
   input  wire logic         preset_required_in,
   input  wire logic         mech_home_established_in,
   input  wire logic         factory_home_established_in,
   input  wire logic         forward_soft_limit_hit_in,
   input  wire logic         reverse_soft_limit_hit_in,
   input  wire logic         cyclic_sync_position_mode_in,
   // event pulses
   input  wire logic         homing_done_pulse_in,
   input  wire logic         preset_done_pulse_in,
   input  wire logic         home_clear_pulse_in,
   input  wire logic         wrap_exceed_pulse_in,
   // terminals
   output term_vec_t         terminal_out,
   output logic              wrap_overflow_toggle_out,
   output logic              home_end_out
);

   assign_code_t code_q [`SOS_NUM_TERMINALS];
   term_vec_t    terminal_q;
   term_vec_t    terminal_d;
   assign_code_t code_rd_q;
   status_vec_t  status_vec;
   logic         home_end_flag;
   logic         wrap_toggle_flag;
   logic         home_set;
   logic         in_position_gated;
   logic         speed_reached_gated;

   // status bit position for a code in the status range
   function automatic int unsigned status_pos(input assign_code_t code);
      assign_code_t offs;
      offs = code - `SOS_CODE_CONST_OFF;
      return int'(offs);
   endfunction : status_pos

   // one terminal's level for a code
   function automatic logic select_level(
      input assign_code_t code,
      input input_vec_t   inputs,
      input status_vec_t  status
   );
      logic level;
      level = 1'b0;
      if (code == `SOS_CODE_UNUSED) begin
         level = 1'b0;
      end else if (code <= `SOS_CODE_ECHO_LAST) begin
         level = inputs[code[`SOS_ECHO_IDX_MSB:0]];
      end else if (code <= `SOS_CODE_STATUS_LAST) begin
         level = status[status_pos(code)];
      end else begin
         level = 1'b0;
      end
      return level;
   endfunction : select_level

   // homing completion and preset share one sticky indication
   assign home_set = homing_done_pulse_in | preset_done_pulse_in;

   sticky_event_flag u_home_end (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .set_in    (home_set),
      .clear_in  (home_clear_pulse_in),
      .flag_out  (home_end_flag)
   );

   event_toggle_flag u_wrap_toggle (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .event_in  (wrap_exceed_pulse_in),
      .level_out (wrap_toggle_flag)
   );

   // sync mode has no positioning or speed target of its own
   assign in_position_gated =
      positioning_done_in & ~cyclic_sync_position_mode_in;
   assign speed_reached_gated =
      speed_reached_in & ~cyclic_sync_position_mode_in;

   // status vector, one bit per code from the constant-off code on;
   // holes stay low so an undefined code reads zero
   always_comb begin
      status_vec = '0;
      status_vec[status_pos(`SOS_CODE_CONST_OFF)]   = 1'b0;
      status_vec[status_pos(`SOS_CODE_ALARM_HIGH)]  =
         alarm_present_in;
      status_vec[status_pos(`SOS_CODE_ALARM_LOW)]   =
         ~alarm_present_in;
      status_vec[status_pos(`SOS_CODE_SYS_PREP)]    =
         system_prepared_in;
      status_vec[status_pos(`SOS_CODE_READY)]       =
         drive_ready_in;
      status_vec[status_pos(`SOS_CODE_MOVING)]      =
         motor_moving_in;
      status_vec[status_pos(`SOS_CODE_INFORMATION_FLAG)]        =
         information_flag_in;
      status_vec[status_pos(`SOS_CODE_BUSY)]        =
         internal_processing_flag_in;
      status_vec[status_pos(`SOS_CODE_IN_POSITION)] =
         in_position_gated;
      status_vec[status_pos(`SOS_CODE_TORQUE_LIM)]  =
         torque_at_limit_in;
      status_vec[status_pos(`SOS_CODE_SPEED_REACH)] =
         speed_reached_gated;
      status_vec[status_pos(`SOS_CODE_EXCITED)]     =
         motor_excited_in;
      status_vec[status_pos(`SOS_CODE_CUTBACK)]     =
         current_cutback_active_in;
      status_vec[status_pos(`SOS_CODE_HOME_END)]    =
         home_end_flag;
      status_vec[status_pos(`SOS_CODE_COORD_SET)]   =
         coordinate_established_in;
      status_vec[status_pos(`SOS_CODE_PRESET_REQ)]  =
         preset_required_in;
      status_vec[status_pos(`SOS_CODE_MECH_HOME)]   =
         mech_home_established_in;
      status_vec[status_pos(`SOS_CODE_FACT_HOME)]   =
         factory_home_established_in;
      status_vec[status_pos(`SOS_CODE_WRAP_TOGGLE)] =
         wrap_toggle_flag;
      status_vec[status_pos(`SOS_CODE_FWD_LIMIT)]   =
         forward_soft_limit_hit_in;
      status_vec[status_pos(`SOS_CODE_REV_LIMIT)]   =
         reverse_soft_limit_hit_in;
   end

   // assignment code store; all terminals start unused
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < `SOS_NUM_TERMINALS; i++) begin
            code_q[i] <= `SOS_CODE_RESET;
         end
      end else if (code_wr_en_in) begin
         code_q[code_wr_sel_in] <= code_wr_data_in;
      end
   end

   // readback shows the stored code one cycle after the select
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         code_rd_q <= `SOS_CODE_RESET;
      end else begin
         code_rd_q <= code_q[code_rd_sel_in];
      end
   end

   // per-terminal selection
   always_comb begin
      terminal_d = '0;
      for (int i = 0; i < `SOS_NUM_TERMINALS; i++) begin
         terminal_d[i] = select_level(code_q[i], input_func_in,
                                      status_vec);
      end
   end

   // registered terminals: one cycle from flag to pin, no glitches
   // when a code is rewritten
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         terminal_q <= '0;
      end else begin
         terminal_q <= terminal_d;
      end
   end

   assign terminal_out             = terminal_q;
   assign code_rd_data_out         = code_rd_q;
   assign wrap_overflow_toggle_out = wrap_toggle_flag;
   assign home_end_out             = home_end_flag;

endmodule : status_output_selector

// ==== host_terminal_reader.sv ====
/* host side model: samples the terminal levels every clock, as a PLC would.
   assumes the terminals are registered levels on the same clock. */
module host_terminal_reader
   import status_output_selector_pkg::*;
(
   input  wire logic      clk_in,
   input  wire term_vec_t terminals_in,
   output term_vec_t      seen_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // the host only observes; it never drives the block
   always_ff @(posedge clk_in) begin
      seen_out <= terminals_in;
   end
endmodule : host_terminal_reader

// ==== status_output_selector_asserts.sv ====
/* assertions on terminal 0 and the event flags of the selector.
   assumes one clock domain; terminal 0's code is shadowed from writes. */
module status_output_selector_asserts
   import status_output_selector_pkg::*;
(
   input wire logic         clk_in,
   input wire logic         arst_n_in,
   input wire logic         code_wr_en_in,
   input wire term_idx_t    code_wr_sel_in,
   input wire assign_code_t code_wr_data_in,
   input wire input_vec_t   input_func_in,
   input wire logic         alarm_present_in,
   input wire logic         positioning_done_in,
   input wire logic         cyclic_sync_position_mode_in,
   input wire logic         homing_done_pulse_in,
   input wire logic         preset_done_pulse_in,
   input wire logic         wrap_exceed_pulse_in,
   input wire term_vec_t    terminal_out,
   input wire logic         wrap_overflow_toggle_out,
   input wire logic         home_end_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   assign_code_t code0_q;
   logic         echo0;
   // the code store is hidden, so keep a copy for terminal 0
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         code0_q <= 8'h00;
      end else if (code_wr_en_in && code_wr_sel_in == 3'h0) begin
         code0_q <= code_wr_data_in;
      end
   end
   assign echo0 = input_func_in[code0_q[6:0]];
   AST_UNUSED: assert property (code0_q == 8'h00
      |=> !terminal_out[0]) else $error("unused terminal high");
   AST_ECHO: assert property (code0_q inside {[8'h01:8'h7f]}
      |=> terminal_out[0] == $past(echo0)) else $error("echo wrong");
   AST_OFF: assert property (code0_q == 8'h80 |=> !terminal_out[0])
      else $error("constant off high");
   AST_ALM_HI: assert property (code0_q == 8'h81
      |=> terminal_out[0] == $past(alarm_present_in)) else $error("alarm");
   AST_ALM_LO: assert property (code0_q == 8'h82
      |=> terminal_out[0] != $past(alarm_present_in)) else $error("alarm b");
   AST_IN_POS: assert property (code0_q == 8'h8a
      |=> terminal_out[0] ==
      $past(positioning_done_in && !cyclic_sync_position_mode_in))
      else $error("positioning done wrong");
   AST_UNDEF: assert property (code0_q inside {8'h85, 8'h89, 8'h8b,
      [8'h92:8'h94], [8'h9b:8'hff]} |=> !terminal_out[0])
      else $error("undefined code high");
   // a pulse at the release edge meets a flop still in reset
   AST_HOME: assert property (arst_n_in && (homing_done_pulse_in
      || preset_done_pulse_in) |=> home_end_out)
      else $error("home flag not set");
   AST_WRAP: assert property (arst_n_in && $past(arst_n_in) |->
      wrap_overflow_toggle_out == ($past(wrap_overflow_toggle_out)
      ^ $past(wrap_exceed_pulse_in))) else $error("wrap toggle wrong");
   cover property (code0_q == 8'h98 && wrap_exceed_pulse_in);
   cover property (code0_q == 8'h8a && cyclic_sync_position_mode_in);
   cover property (code0_q == 8'h90 && homing_done_pulse_in);
endmodule : status_output_selector_asserts
bind status_output_selector status_output_selector_asserts
   status_output_selector_asserts_inst (
      .clk_in                       (clk_in),
      .arst_n_in                    (arst_n_in),
      .code_wr_en_in                (code_wr_en_in),
      .code_wr_sel_in               (code_wr_sel_in),
      .code_wr_data_in              (code_wr_data_in),
      .input_func_in                (input_func_in),
      .alarm_present_in             (alarm_present_in),
      .positioning_done_in          (positioning_done_in),
      .cyclic_sync_position_mode_in (cyclic_sync_position_mode_in),
      .homing_done_pulse_in         (homing_done_pulse_in),
      .preset_done_pulse_in         (preset_done_pulse_in),
      .wrap_exceed_pulse_in         (wrap_exceed_pulse_in),
      .terminal_out                 (terminal_out),
      .wrap_overflow_toggle_out     (wrap_overflow_toggle_out),
      .home_end_out                 (home_end_out)
   );

// ==== tb_top.sv ====
/* self-checking bench: random flags and a sweep of every code, compared
   each cycle with a model. assumes the design's package and header. */
module tb_top
   import status_output_selector_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 0, arst_n_in = 0, wr_en = 0, wrap, home;
   term_idx_t wr_sel = 0, rd_sel = 0;
   assign_code_t wr_data = 0, rd_data;
   input_vec_t inf = 0;
   logic [17:0] st = 0;
   logic [3:0] ev = 0;
   term_vec_t term, seen, last_et = '0;
   int fails = 0, checks = 0, seed = 32'h0c58ffb5, mhome, mwrap;
   int mcode[8];
   status_output_selector status_output_selector_inst (.clk_in(clk_in),
      .arst_n_in(arst_n_in), .code_wr_en_in(wr_en), .code_wr_sel_in(wr_sel),
      .code_wr_data_in(wr_data), .code_rd_sel_in(rd_sel),
      .code_rd_data_out(rd_data), .input_func_in(inf),
      .alarm_present_in(st[0]), .system_prepared_in(st[1]),
      .drive_ready_in(st[2]), .motor_moving_in(st[3]),
      .information_flag_in(st[4]), .internal_processing_flag_in(st[5]),
      .positioning_done_in(st[6]), .torque_at_limit_in(st[7]),
      .speed_reached_in(st[8]), .motor_excited_in(st[9]),
      .current_cutback_active_in(st[10]), .coordinate_established_in(st[11]),
      .preset_required_in(st[12]), .mech_home_established_in(st[13]),
      .factory_home_established_in(st[14]),
      .forward_soft_limit_hit_in(st[15]), .reverse_soft_limit_hit_in(st[16]),
      .cyclic_sync_position_mode_in(st[17]), .homing_done_pulse_in(ev[0]),
      .preset_done_pulse_in(ev[1]), .home_clear_pulse_in(ev[2]),
      .wrap_exceed_pulse_in(ev[3]), .terminal_out(term),
      .wrap_overflow_toggle_out(wrap), .home_end_out(home));
   host_terminal_reader host_terminal_reader_inst (.clk_in(clk_in),
      .terminals_in(term), .seen_out(seen));
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   function automatic int expect_bit(int c);
      case (c)
         129: return st[0];
         130: return !st[0];
         131: return st[1];
         132: return st[2];
         134: return st[3];
         135: return st[4];
         136: return st[5];
         138: return st[6] && !st[17];
         140: return st[7];
         141: return st[8] && !st[17];
         142: return st[9];
         143: return st[10];
         144: return mhome;
         145: return st[11];
         149: return st[12];
         150: return st[13];
         151: return st[14];
         152: return mwrap;
         153: return st[15];
         154: return st[16];
         default: return (c >= 1 && c <= 127) ? inf[c] : 0;
      endcase
   endfunction : expect_bit
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic step(int k);
      logic [7:0] et, er;
      @(posedge clk_in);
      for (int i = 0; i < 8; i++) et[i] = 1'(expect_bit(mcode[i]));
      er = 8'(mcode[rd_sel]);
      if (arst_n_in) begin
         if (wr_en) mcode[wr_sel] = wr_data;
         // set wins when a clear lands in the same cycle
         if (ev[0] || ev[1]) mhome = 1;
         else if (ev[2]) mhome = 0;
         mwrap ^= ev[3];
      end
      wr_en <= k[0];
      wr_data <= k[10:3];
      wr_sel <= 3'($random(seed));
      rd_sel <= 3'($random(seed));
      inf <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      st <= 18'($random(seed));
      ev <= 4'($random(seed) & $random(seed));
      arst_n_in <= !(k >= 2000 && k < 2004);
      #1;
      // a reset raised at this edge clears the design at once
      if (!arst_n_in) begin
         et = 0;
         er = 0;
         mcode = '{default: 0};
         mhome = 0;
         mwrap = 0;
      end
      cmp("terminals", et, term);
      cmp("terminals", et, term);
      cmp("terminals", et, term);
      cmp("readback", er, rd_data);
      cmp("home flag", 8'(mhome), {7'h00, home});
      cmp("wrap flag", 8'(mwrap), {7'h00, wrap});
      // the host sees last cycle's terminals
      cmp("host view", last_et, seen);
      last_et = et;
   endtask : step
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      for (int k = 0; k < 4096; k++) step(k);
      give_verdict();
   end
endmodule : tb_top
